// ### common/wdg_div_if.sv
// Control and status between watchdog core and its divider chain
`timescale 1ns/10ps
interface wdg_div_if;
  logic                         run;
  logic                         clear;
  logic                         pre_long;
  logic [wdg_pkg::POST_W-1:0]   post_sel;
  logic [wdg_pkg::CNT_W-1:0]    count;
  logic                         early;
  logic                         timeout;
  modport ctrl (output run, clear, pre_long, post_sel,
                input  count, early, timeout);
  modport div  (input  run, clear, pre_long, post_sel,
                output count, early, timeout);
endinterface

// ### common/wdg_pkg.sv
// Shared constants and types for the windowed watchdog
package wdg_pkg;
  // Timing: system clock and nominal low-power RC oscillator
  localparam int unsigned CLK_HZ       = 200_000_000;
  localparam int unsigned RC_OSC_HZ    = 32_000;
  localparam int unsigned RC_CYCLES    = CLK_HZ / RC_OSC_HZ;
  // Divider structure
  localparam int          PRE_SHORT_LOG2 = 5;
  localparam int          PRE_LONG_LOG2  = 7;
  localparam int          POST_W         = 4;
  localparam int          SHAMT_W        = 5;
  localparam int          CNT_W          = 22;
  // APB register map
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  ADDR_CFG    = 8'h00;
  localparam logic [7:0]  ADDR_RCTL   = 8'h04;
  localparam logic [7:0]  ADDR_IST    = 8'h08;
  localparam logic [7:0]  ADDR_IMASK  = 8'h0C;
  localparam logic [7:0]  ADDR_CNT    = 8'h10;
  // Configuration word fields
  localparam int          CFG_W          = 8;
  localparam int          CFG_POST_LSB   = 0;
  localparam int          CFG_PRE_BIT    = 4;
  localparam int          CFG_WINOFF_BIT = 6;
  localparam int          CFG_FIXEN_BIT  = 7;
  localparam logic [7:0]  CFG_RESET      = 8'h5F;
  // Reset control register fields
  localparam int          RC_IDLE_BIT  = 2;
  localparam int          RC_SLEEP_BIT = 3;
  localparam int          RC_TO_BIT    = 4;
  localparam int          RC_SWEN_BIT  = 5;
  // Interrupt status and mask fields
  localparam int          IRQ_W        = 3;
  localparam int          IRQ_TO_BIT   = 0;
  localparam int          IRQ_WIN_BIT  = 1;
  localparam int          IRQ_WAKE_BIT = 2;
  localparam logic [2:0]  IRQ_RESET    = 3'h0;

  typedef enum logic [1:0] {
    WDG_RUN,
    WDG_SLEEP,
    WDG_IDLE
  } wdg_mode_t;
endpackage

// ### src/wdg_divider.sv
// Low-power RC tick source with prescaler and postscaler count
`timescale 1ns/10ps
module wdg_divider #(
  parameter int unsigned RC_CYCLES = wdg_pkg::RC_CYCLES
) (
  // Clock and reset
  input  wire logic  clk_sys_in,
  input  wire logic  sys_rst_in,
  // Divider control
  wdg_div_if.div     div_if
);
  localparam int OSC_W = $clog2(RC_CYCLES);
  localparam int CW    = wdg_pkg::CNT_W;

  if (RC_CYCLES < 2) begin : g_chk
    $error("RC_CYCLES must be at least 2");
  end

  logic [OSC_W-1:0]            osc_reg;
  logic [CW-1:0]               count_reg;
  logic                        timeout_reg;
  logic                        osc_tick;
  logic [wdg_pkg::SHAMT_W-1:0] shamt;
  logic [CW-1:0]               last;
  logic [CW-1:0]               win_start;
  logic                        at_end;

  assign osc_tick = (osc_reg == OSC_W'(RC_CYCLES - 1));
  // Prescaler and postscaler form one count: low bits are the prescaler
  assign shamt = (div_if.pre_long
                  ? wdg_pkg::SHAMT_W'(wdg_pkg::PRE_LONG_LOG2)
                  : wdg_pkg::SHAMT_W'(wdg_pkg::PRE_SHORT_LOG2))
                 + wdg_pkg::SHAMT_W'(div_if.post_sel);
  assign last      = (CW'(1) << shamt) - CW'(1);
  assign win_start = last - (last >> 2);
  // A live ratio change may leave the count above the new end
  assign at_end    = (count_reg >= last);

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || !div_if.run || osc_tick) begin
      osc_reg <= '0;
    end else begin
      osc_reg <= osc_reg + OSC_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || div_if.clear) begin
      count_reg <= '0;
    end else if (div_if.run && osc_tick) begin
      count_reg <= at_end ? '0 : count_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || div_if.clear) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= div_if.run && osc_tick && at_end;
    end
  end

  assign div_if.count   = count_reg;
  assign div_if.timeout = timeout_reg;
  assign div_if.early   = (count_reg < win_start);

  a_wrap_period: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    div_if.run && osc_tick && at_end && !div_if.clear
    |=> timeout_reg && count_reg == '0)
    else $error("count did not wrap with timeout at period end");
  a_osc_stopped: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    !div_if.run && !div_if.clear |=> osc_reg == '0 && $stable(count_reg))
    else $error("divider moved while watchdog disabled");
endmodule

// ### src/wdg_watchdog.sv
// Windowed watchdog with APB registers, power-save and wake handling
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module wdg_watchdog #(
  parameter int unsigned RC_CYCLES = wdg_pkg::RC_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        sys_rst_in,
  // APB slave
  input  wire logic                        psel_in,
  input  wire logic                        penable_in,
  input  wire logic                        pwrite_in,
  input  wire logic [wdg_pkg::ADDR_W-1:0]  paddr_in,
  input  wire logic [31:0]                 pwdata_in,
  output logic      [31:0]                 prdata_out,
  output logic                             pready_out,
  output logic                             pslverr_out,
  // Processor core events
  input  wire logic                        dog_clear_instr_in,
  input  wire logic                        power_save_instr_in,
  input  wire logic                        power_save_idle_in,
  input  wire logic                        clk_switch_done_in,
  input  wire logic                        wake_event_in,
  // Device control
  output logic                             dev_reset_out,
  output logic                             wake_out,
  output logic                             sleep_out,
  output logic                             idle_out,
  output logic                             osc_enable_out,
  output logic                             irq_out
);
  wdg_div_if div_if ();

  wdg_divider #(
    .RC_CYCLES (RC_CYCLES)
  ) u_divider (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .div_if     (div_if)
  );

  logic [wdg_pkg::CFG_W-1:0]  cfg_reg;
  logic                       soft_en_reg;
  logic                       to_flag_reg;
  logic                       sleep_st_reg;
  logic                       idle_st_reg;
  logic [wdg_pkg::IRQ_W-1:0]  ist_reg;
  logic [wdg_pkg::IRQ_W-1:0]  ist_next;
  logic [wdg_pkg::IRQ_W-1:0]  imask_reg;
  wdg_pkg::wdg_mode_t         mode_reg;
  wdg_pkg::wdg_mode_t         mode_next;
  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;
  logic                       dev_reset_reg;
  logic                       wake_reg;
  logic                       sleep_reg;
  logic                       idle_reg;
  logic                       osc_en_reg;
  logic                       irq_reg;

  logic                       run;
  logic                       in_run;
  logic                       apb_setup;
  logic                       wr_acc;
  logic                       wr_cfg;
  logic                       wr_rctl;
  logic                       wr_ist;
  logic                       wr_imask;
  logic [31:0]                rdata;
  logic                       addr_ok;
  logic                       clr_cmd;
  logic                       win_err;
  logic                       ps_take;
  logic                       to_run;
  logic                       to_low;
  logic                       exit_low;
  logic                       dog_rst;

  assign run    = cfg_reg[wdg_pkg::CFG_FIXEN_BIT] | soft_en_reg;
  assign in_run = (mode_reg == wdg_pkg::WDG_RUN);

  // APB decode: writes land on the edge that samples pready high
  assign apb_setup = psel_in && penable_in && !pready_reg;
  assign wr_acc    = psel_in && penable_in && pready_reg && pwrite_in;
  assign wr_cfg    = wr_acc && (paddr_in == wdg_pkg::ADDR_CFG);
  assign wr_rctl   = wr_acc && (paddr_in == wdg_pkg::ADDR_RCTL);
  assign wr_ist    = wr_acc && (paddr_in == wdg_pkg::ADDR_IST);
  assign wr_imask  = wr_acc && (paddr_in == wdg_pkg::ADDR_IMASK);

  // Core-side events
  // clear only in normal run
  assign clr_cmd  = dog_clear_instr_in && in_run;
  assign win_err  = clr_cmd && run && div_if.early &&
                    !cfg_reg[wdg_pkg::CFG_WINOFF_BIT];
  assign ps_take  = power_save_instr_in && in_run;
  assign to_run   = div_if.timeout && in_run;
  // time-out still arrives in low power
  assign to_low   = div_if.timeout && !in_run;
  assign exit_low = !in_run && (to_low || wake_event_in);
  assign dog_rst  = to_run || win_err;

  // Divider control
  assign div_if.run      = run;
  assign div_if.pre_long = cfg_reg[wdg_pkg::CFG_PRE_BIT];
  assign div_if.post_sel =
    cfg_reg[wdg_pkg::CFG_POST_LSB +: wdg_pkg::POST_W];
  assign div_if.clear = clk_switch_done_in || ps_take || exit_low ||
                        clr_cmd || dog_rst;

  // Power-save state
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      wdg_pkg::WDG_RUN: begin
        if (ps_take) begin
          mode_next = power_save_idle_in ? wdg_pkg::WDG_IDLE
                                         : wdg_pkg::WDG_SLEEP;
        end
      end
      wdg_pkg::WDG_SLEEP, wdg_pkg::WDG_IDLE: begin
        if (exit_low) begin
          mode_next = wdg_pkg::WDG_RUN;
        end
      end
      default: begin
        mode_next = wdg_pkg::WDG_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      mode_reg  <= wdg_pkg::WDG_RUN;
      sleep_reg <= 1'b0;
      idle_reg  <= 1'b0;
      wake_reg  <= 1'b0;
    end else begin
      mode_reg  <= mode_next;
      sleep_reg <= (mode_next == wdg_pkg::WDG_SLEEP);
      idle_reg  <= (mode_next == wdg_pkg::WDG_IDLE);
      wake_reg  <= exit_low;
    end
  end

  // Configuration word; fixed enable cannot be cleared once set
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      cfg_reg <= wdg_pkg::CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= pwdata_in[wdg_pkg::CFG_W-1:0] |
                 (cfg_reg & (wdg_pkg::CFG_W'(1) << wdg_pkg::CFG_FIXEN_BIT));
    end
  end

  // soft enable cleared on any reset
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in || dog_rst) begin
      soft_en_reg <= 1'b0;
    end else if (wr_rctl) begin
      soft_en_reg <= pwdata_in[wdg_pkg::RC_SWEN_BIT];
    end
  end

  // Status bits: hardware sets, software writes zero to clear, set wins
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      to_flag_reg  <= 1'b0;
      sleep_st_reg <= 1'b0;
      idle_st_reg  <= 1'b0;
    end else begin
      to_flag_reg  <= div_if.timeout ||
                      (to_flag_reg &&
                       !(wr_rctl && !pwdata_in[wdg_pkg::RC_TO_BIT]));
      sleep_st_reg <= (ps_take && !power_save_idle_in) ||
                      (sleep_st_reg &&
                       !(wr_rctl && !pwdata_in[wdg_pkg::RC_SLEEP_BIT]));
      idle_st_reg  <= (ps_take && power_save_idle_in) ||
                      (idle_st_reg &&
                       !(wr_rctl && !pwdata_in[wdg_pkg::RC_IDLE_BIT]));
    end
  end

  // Interrupt status, write one to clear, set wins over clear
  always_comb begin
    ist_next = ist_reg;
    if (wr_ist) begin
      ist_next = ist_reg & ~pwdata_in[wdg_pkg::IRQ_W-1:0];
    end
    ist_next[wdg_pkg::IRQ_TO_BIT]   = ist_next[wdg_pkg::IRQ_TO_BIT] |
                                      div_if.timeout;
    ist_next[wdg_pkg::IRQ_WIN_BIT]  = ist_next[wdg_pkg::IRQ_WIN_BIT] |
                                      win_err;
    ist_next[wdg_pkg::IRQ_WAKE_BIT] = ist_next[wdg_pkg::IRQ_WAKE_BIT] |
                                      exit_low;
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      ist_reg   <= wdg_pkg::IRQ_RESET;
      imask_reg <= wdg_pkg::IRQ_RESET;
      irq_reg   <= 1'b0;
    end else begin
      ist_reg <= ist_next;
      if (wr_imask) begin
        imask_reg <= pwdata_in[wdg_pkg::IRQ_W-1:0];
      end
      // One cycle behind status; keeps the pin straight from a flop
      irq_reg <= |(ist_reg & imask_reg);
    end
  end

  // Device reset request and oscillator enable
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      dev_reset_reg <= 1'b0;
      osc_en_reg    <= 1'b0;
    end else begin
      dev_reset_reg <= dog_rst;
      osc_en_reg    <= run;
    end
  end

  // Read mux
  always_comb begin
    rdata   = 32'h0000_0000;
    addr_ok = 1'b1;
    case (paddr_in)
      wdg_pkg::ADDR_CFG:   rdata = 32'(cfg_reg);
      wdg_pkg::ADDR_RCTL: begin
        rdata[wdg_pkg::RC_SWEN_BIT]  = soft_en_reg;
        rdata[wdg_pkg::RC_TO_BIT]    = to_flag_reg;
        rdata[wdg_pkg::RC_SLEEP_BIT] = sleep_st_reg;
        rdata[wdg_pkg::RC_IDLE_BIT]  = idle_st_reg;
      end
      wdg_pkg::ADDR_IST:   rdata = 32'(ist_reg);
      wdg_pkg::ADDR_IMASK: rdata = 32'(imask_reg);
      wdg_pkg::ADDR_CNT:   rdata = 32'(div_if.count);
      default:             addr_ok = 1'b0;
    endcase
  end

  // APB answer: one wait state in every access phase
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= apb_setup;
      pslverr_reg <= apb_setup && !addr_ok;
      if (apb_setup && !pwrite_in) begin
        prdata_reg <= rdata;
      end
    end
  end

  assign prdata_out     = prdata_reg;
  assign pready_out     = pready_reg;
  assign pslverr_out    = pslverr_reg;
  assign dev_reset_out  = dev_reset_reg;
  assign wake_out       = wake_reg;
  assign sleep_out      = sleep_reg;
  assign idle_out       = idle_reg;
  assign osc_enable_out = osc_en_reg;
  assign irq_out        = irq_reg;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_osc_follows_en: assert property (run |=> osc_enable_out)
    else $error("oscillator not enabled while watchdog runs");
  a_fixed_always: assert property (
    cfg_reg[wdg_pkg::CFG_FIXEN_BIT] |=> ##1 osc_enable_out)
    else $error("fixed enable did not keep watchdog running");
  a_soft_gates_run: assert property (
    !cfg_reg[wdg_pkg::CFG_FIXEN_BIT] && !soft_en_reg && !wr_cfg &&
    !wr_rctl |=> ##1 !osc_enable_out)
    else $error("watchdog ran without any enable");
  a_run_timeout_rst: assert property (
    to_run |=> dev_reset_out && to_flag_reg && !wake_out)
    else $error("run time-out did not reset and flag");
  a_sleep_wakeup: assert property (
    to_low |=> wake_out && in_run && !dev_reset_out)
    else $error("low-power time-out did not wake cleanly");
  a_flag_sticky: assert property (
    to_flag_reg && !wr_rctl |=> to_flag_reg)
    else $error("time-out flag dropped without software");
  a_soften_reset: assert property (
    dog_rst |=> !soft_en_reg)
    else $error("soft enable survived watchdog reset");
  a_window_early: assert property (
    win_err |=> dev_reset_out && ist_reg[wdg_pkg::IRQ_WIN_BIT])
    else $error("early clear did not reset");
  a_save_clear: assert property (
    ps_take |=> div_if.count == '0 && !in_run)
    else $error("power-save entry did not clear count");
  a_exit_clear: assert property (
    exit_low |=> div_if.count == '0 && in_run)
    else $error("low-power exit did not clear count");
  a_switch_clear: assert property (
    clk_switch_done_in |=> div_if.count == '0)
    else $error("clock switch did not clear count");
  a_clear_instr: assert property (
    clr_cmd |=> div_if.count == '0 && !div_if.timeout)
    else $error("clear instruction did not clear count");

  c_run_timeout:  cover property (to_run);
  c_sleep_wake:   cover property (to_low);
  c_window_error: cover property (win_err);
  c_irq_raised:   cover property (irq_out);
endmodule

// ### tb/tb.sv
// Self-checking bench for the windowed watchdog
`timescale 1ns/10ps
module tb;
  localparam int LP = 4;
  localparam int P0 = 32 * LP;
  logic        clk_sys_in;
  logic        sys_rst_in;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clr;
  logic        save;
  logic        sidle;
  logic        swd;
  logic        wev;
  logic        dev_rst;
  logic        wake;
  logic        slp;
  logic        idl;
  logic        osc;
  logic        irq;
  logic [31:0] rd;
  logic        err;
  logic        w;
  int          n;
  int          e;
  int          errors;
  int          checks;
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [31:0] rv [5] = '{32'h5F, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [7:0]  cf [3] = '{8'h40, 8'h41, 8'h50};

  wdg_watchdog #(.RC_CYCLES(LP)) dut (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .dog_clear_instr_in(clr), .power_save_instr_in(save),
    .power_save_idle_in(sidle), .clk_switch_done_in(swd),
    .wake_event_in(wev), .dev_reset_out(dev_rst), .wake_out(wake),
    .sleep_out(slp), .idle_out(idl), .osc_enable_out(osc),
    .irq_out(irq));

  wdg_core_model core (
    .clk_sys_in(clk_sys_in), .dog_clear_instr_out(clr),
    .power_save_instr_out(save), .power_save_idle_out(sidle),
    .clk_switch_done_out(swd), .wake_event_out(wev));

  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    // Wait for the answer; only the watchdog ends a hung access
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // Counts clocks until a watchdog reset or wake pulse, or the limit
  task automatic wait_ev(input int lim);
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (dev_rst !== 1'b1 && wake !== 1'b1 && n < lim);
    w = wake;
  endtask

  task automatic do_reset(input int cyc);
    sys_rst_in <= 1'b1;
    repeat (cyc) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Whole run needs about 2400 clocks; allow plenty more
  initial begin
    #200000;
    errors++;
    print_verdict();
  end

  initial begin
    errors = 0;
    checks = 0;
    sys_rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    do_reset(8);
    for (int i = 0; i < 5; i++) begin
      rchk(ra[i], rv[i]);
    end
    rchk(8'h14, 32'h0);
    chk(32'(err), 32'h1);
    chk(32'(osc), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      do_reset(2);
      e = 5 + (cf[i][4] ? 2 : 0) + int'(cf[i][3:0]);
      apb(1'b1, 8'h0C, 32'h7);
      apb(1'b1, 8'h00, 32'(cf[i]));
      apb(1'b1, 8'h04, 32'h20);
      // Enable reaches the oscillator pin one edge after the write; checked after the second
      repeat (2) @(posedge clk_sys_in);
      chk(32'(osc), 32'h1);
      wait_ev(3000);
      chk(32'(w), 32'h0);
      chk_rng(n, (LP << e) - 12, (LP << e) + 8);
      rchk(8'h04, 32'h10);
      rchk(8'h08, 32'h1);
      chk(32'(irq), 32'h1);
      apb(1'b1, 8'h08, 32'h1);
      rchk(8'h08, 32'h0);
      chk(32'(irq), 32'h0);
      apb(1'b1, 8'h04, 32'h0);
      rchk(8'h04, 32'h0);
    end
    $display("test timeout done");
    do_reset(2);
    apb(1'b1, 8'h00, 32'h40);
    apb(1'b1, 8'h04, 32'h20);
    for (int i = 0; i < 6; i++) begin
      repeat (90) @(posedge clk_sys_in);
      core.pulse((i % 2) * 2, 1'b0);
    end
    wait_ev(30);
    chk_rng(n, 30, 30);
    rchk(8'h04, 32'h20);
    $display("test clear done");
    core.pulse(0, 1'b0);
    repeat (60) @(posedge clk_sys_in);
    core.pulse(1, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(slp), 32'h1);
    wait_ev(400);
    chk(32'(w), 32'h1);
    chk_rng(n, P0 - 12, P0 + 8);
    chk(32'(slp), 32'h0);
    rchk(8'h04, 32'h38);
    apb(1'b1, 8'h04, 32'h20);
    rchk(8'h04, 32'h20);
    core.pulse(1, 1'b1);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(idl), 32'h1);
    repeat (60) @(posedge clk_sys_in);
    core.pulse(3, 1'b0);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(idl), 32'h0);
    wait_ev(400);
    chk(32'(w), 32'h0);
    chk_rng(n, P0 - 12, P0 + 8);
    $display("test low power done");
    do_reset(2);
    apb(1'b1, 8'h00, 32'h00);
    apb(1'b1, 8'h04, 32'h20);
    repeat (20) @(posedge clk_sys_in);
    core.pulse(0, 1'b0);
    wait_ev(6);
    chk_rng(n, 0, 3);
    rchk(8'h08, 32'h2);
    apb(1'b1, 8'h04, 32'h20);
    repeat (110) @(posedge clk_sys_in);
    core.pulse(0, 1'b0);
    wait_ev(30);
    chk_rng(n, 30, 30);
    $display("test window done");
    do_reset(2);
    rchk(8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'hC0);
    apb(1'b1, 8'h04, 32'h0);
    chk(32'(osc), 32'h1);
    wait_ev(400);
    chk_rng(n, P0 - 20, P0 + 8);
    rchk(8'h04, 32'h10);
    apb(1'b1, 8'h00, 32'h40);
    rchk(8'h00, 32'hC0);
    $display("test fixed enable done");
    print_verdict();
  end
endmodule

// ### tb/wdg_core_model.sv
// Processor core model that issues watchdog events
`timescale 1ns/10ps
module wdg_core_model (
  // Clock
  input  wire logic clk_sys_in,
  // Core events
  output logic      dog_clear_instr_out,
  output logic      power_save_instr_out,
  output logic      power_save_idle_out,
  output logic      clk_switch_done_out,
  output logic      wake_event_out
);
  initial begin
    dog_clear_instr_out = 1'b0;
    power_save_instr_out = 1'b0;
    power_save_idle_out = 1'b0;
    clk_switch_done_out = 1'b0;
    wake_event_out = 1'b0;
  end

  // Kinds: 0 clear, 1 power save, 2 clock switch, 3 wake source
  task automatic pulse(input int kind, input logic idle);
    @(posedge clk_sys_in);
    power_save_idle_out <= idle;
    case (kind)
      0: dog_clear_instr_out <= 1'b1;
      1: power_save_instr_out <= 1'b1;
      2: clk_switch_done_out <= 1'b1;
      default: wake_event_out <= 1'b1;
    endcase
    @(posedge clk_sys_in);
    dog_clear_instr_out <= 1'b0;
    power_save_instr_out <= 1'b0;
    clk_switch_done_out <= 1'b0;
    wake_event_out <= 1'b0;
    // Mode line only means something with the pulse, so it wanders
    power_save_idle_out <= ~idle;
  endtask
endmodule
